// [sas_pkg.sv]
// sas_pkg: constants, field layouts and types for the converter sequencer
package sas_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W = 8;
    localparam int CH_N = 8;
    localparam int CH_W = 3;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 8;
    localparam int INSEL_W = 4;

    // ****************************************
    // register addresses and reset values
    // ****************************************
    localparam logic [15:0] ADDR_MODE = 16'hFF80;
    localparam logic [15:0] ADDR_RESULT = 16'hFF81;
    localparam logic [15:0] ADDR_INSEL = 16'hFF84;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [3:0] INSEL_RESET = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] SAR_MSB = 8'h80;

    // ****************************************
    // conversion timing, in main-clock cycles
    // ****************************************
    // total conversion lengths selected by the rate field and speed bit
    localparam int CONV_CLK_160 = 160;
    localparam int CONV_CLK_80 = 80;
    localparam int CONV_CLK_100 = 100;
    localparam int CONV_CLK_200 = 200;
    // a conversion is ten equal slots: two for sampling, eight for bit decisions
    localparam int SLOTS_PER_CONV = 10;
    localparam int SAMPLE_SLOTS = 2;
    localparam logic [7:0] STEP_160 = 8'(CONV_CLK_160 / SLOTS_PER_CONV);
    localparam logic [7:0] STEP_80 = 8'(CONV_CLK_80 / SLOTS_PER_CONV);
    localparam logic [7:0] STEP_100 = 8'(CONV_CLK_100 / SLOTS_PER_CONV);
    localparam logic [7:0] STEP_200 = 8'(CONV_CLK_200 / SLOTS_PER_CONV);
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    // rate codes {rate, hsc}
    localparam logic [2:0] RATE_160 = 3'h1;
    localparam logic [2:0] RATE_80 = 3'h3;
    localparam logic [2:0] RATE_100 = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic run;
        logic trig_sel;
        logic [1:0] rate;
        logic [2:0] chan;
        logic hsc;
    } sas_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_DECIDE = 2'b10
    } sas_state_t;

endpackage

// [sas_sar_core.sv]
// sas_sar_core: approximation register stepping from msb to lsb
`timescale 1ns/100ps
module sas_sar_core
    import sas_pkg::*;
#(
    parameter int W = DATA_W
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // step control
    input wire logic load,
    input wire logic decide,
    input wire logic comp_ge,
    // state
    output logic [W-1:0] approx,
    output logic [W-1:0] decided,
    output logic last
);

    logic [W-1:0] approx_q;
    logic [W-1:0] approx_d;
    logic [W-1:0] trial_q;
    logic [W-1:0] trial_d;
    logic [W-1:0] msb;

    assign msb = {1'b1, {(W-1){1'b0}}};

    // keep the trial bit only when the input is at least the tap
    assign decided = comp_ge ? approx_q : (approx_q & ~trial_q); // R16
    assign approx = approx_q;
    assign last = trial_q[0];

    // next trial: msb on load, then one bit lower after each decision
    always_comb
    begin
        approx_d = approx_q;
        trial_d = trial_q;
        if (load)
        begin
            approx_d = msb; // R07
            trial_d = msb;
        end
        else if (decide)
        begin
            approx_d = decided | (trial_q >> 1); // R07 R16
            trial_d = trial_q >> 1;
        end
    end

    // register the approximation and trial pointer
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            approx_q <= '0;
            trial_q <= '0;
        end
        else
        begin
            approx_q <= approx_d;
            trial_q <= trial_d;
        end
    end

    // a decision without a load moves the trial bit one place down
    a_trial_shift: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decide && !load |=> trial_q == ($past(trial_q) >> 1)) // R07
        else $error("trial bit did not step down");

endmodule

// [sas_sequencer.sv]
// sas_sequencer: eight-channel 8-bit successive approximation converter control
//
// Function
// [R01] converts one of eight channels into an unsigned 8-bit code per conversion
// [R02] hardware start mode begins a conversion on an external trigger edge
// [R03] software start mode begins converting when software writes the mode register
// [R04] trigger-launched conversion stops after completion and raises done once
// [R05] software-launched conversion repeats back to back, done after each one
// [R06] exactly one selected input is routed to sample-and-hold per conversion
// [R07] approximation bits are decided one at a time from msb to lsb
// [R08] after the lsb decision the whole approximation goes to the result register
// [R09] result register is 8 bits, readable as a byte, undefined after reset
// [R10] sample-and-hold stays in hold for the whole bit-decision phase
// [R11] pins not configured as analog stay available as digital port pins
// [R12] software should not read the shared port during a conversion
// [R13] run bit one starts converter operation, zero stops it
// [R14] trigger select zero means software start, one means hardware start
// [R15] three-bit channel field codes 000..111 select channels zero to seven
// [R16] each trial bit is set, its tap shown, and kept if input is at least tap
// [R17] each conversion is a fixed sampling interval plus eight equal decision steps
`timescale 1ns/100ps
module sas_sequencer
    import sas_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // trigger and interrupt request
    input wire logic external_trigger_input,
    output logic conversion_done_irq,
    // analog front end
    output logic [CH_N-1:0] analog_sel,
    output logic sample_hold,
    output logic [DATA_W-1:0] ladder_tap,
    input wire logic comp_ge,
    // port pin sharing
    output logic [CH_N-1:0] port_analog_mask
);

    // ****************************************
    // declarations
    // ****************************************
    sas_mode_t mode_q;
    sas_mode_t mode_d;
    sas_mode_t wmode;
    logic [INSEL_W-1:0] insel_q;
    logic [INSEL_W-1:0] insel_d;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] result_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    sas_state_t st_q;
    sas_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic src_hw_q;
    logic src_hw_d;
    logic irq_q;
    logic irq_d;
    logic [CH_N-1:0] sel_q;
    logic [CH_N-1:0] sel_d;
    logic hold_q;
    logic hold_d;
    logic cmp_s1_q;
    logic cmp_s2_q;
    logic trg_s1_q;
    logic trg_s2_q;
    logic trg_s3_q;
    logic trig_edge;
    logic wr_mode;
    logic wr_insel;
    logic sw_start;
    logic hw_start;
    logic sar_load;
    logic sar_decide;
    logic sar_last;
    logic [DATA_W-1:0] sar_approx;
    logic [DATA_W-1:0] sar_decided;
    logic [CNT_W-1:0] step_len;
    logic [CNT_W-1:0] sample_len;

    // ****************************************
    // input synchronisers
    // ****************************************
    // comparator passes two flops, trigger pin three; trigger edge from the second against the third
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_s3_q <= 1'b0;
        end
        else
        begin
            cmp_s1_q <= comp_ge;
            cmp_s2_q <= cmp_s1_q;
            trg_s1_q <= external_trigger_input;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
        end
    end

    assign trig_edge = trg_s2_q & ~trg_s3_q; // rising edge is the valid event

    // ****************************************
    // register file
    // ****************************************
    assign wmode = sas_mode_t'(reg_wdata);
    assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
    assign wr_insel = reg_wr && (reg_addr == ADDR_INSEL);

    // register writes, read data and result capture
    always_comb
    begin
        mode_d = wr_mode ? wmode : mode_q;
        insel_d = wr_insel ? reg_wdata[INSEL_W-1:0] : insel_q;
        result_d = (sar_decide && sar_last) ? sar_decided : result_q; // R01 R08
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_MODE: rdata_d = mode_q;
                ADDR_RESULT: rdata_d = result_q; // R09
                ADDR_INSEL: rdata_d = {{(DATA_W-INSEL_W){1'b0}}, insel_q};
                default: rdata_d = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= sas_mode_t'(MODE_RESET);
            insel_q <= INSEL_RESET;
            rdata_q <= READ_ZERO;
        end
        else
        begin
            mode_q <= mode_d;
            insel_q <= insel_d;
            rdata_q <= rdata_d;
        end
    end

    // result has no reset, its content is undefined until the first conversion
    always_ff @(posedge sys_clk)
    begin
        result_q <= result_d; // R09
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // pin sharing
    // ****************************************
    // channels below the configured count are analog, the rest stay digital
    generate
        for (genvar i = 0; i < CH_N; i++)
        begin : g_mask
            assign port_analog_mask[i] = (insel_q > INSEL_W'(i)); // R11
        end
    endgenerate

    // ****************************************
    // conversion timing
    // ****************************************
    // decision step length from the rate field; prohibited codes use the slowest
    // the value being written counts, so a restarting write times its own sampling
    always_comb
    begin
        case ({mode_d.rate, mode_d.hsc})
            RATE_160: step_len = STEP_160; // R17
            RATE_80: step_len = STEP_80;
            RATE_100: step_len = STEP_100;
            default: step_len = STEP_200;
        endcase
        sample_len = CNT_W'(step_len * SAMPLE_SLOTS);
    end

    // ****************************************
    // sequencer
    // ****************************************
    assign sw_start = wr_mode && wmode.run && !wmode.trig_sel; // R03 R13 R14
    assign hw_start = trig_edge && mode_q.run && mode_q.trig_sel && (st_q == ST_IDLE); // R02 R14

    // state, step counter, start source and done pulse
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        src_hw_d = src_hw_q;
        irq_d = 1'b0;
        sar_load = 1'b0;
        sar_decide = 1'b0;
        if (sw_start || hw_start)
        begin
            st_d = ST_SAMPLE;
            cnt_d = sample_len - CNT_ONE; // R17
            src_hw_d = hw_start;
        end
        else if (!mode_q.run)
        begin
            st_d = ST_IDLE; // R13
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    cnt_d = CNT_ZERO;
                end
                ST_SAMPLE:
                begin
                    if (cnt_q == CNT_ZERO)
                    begin
                        sar_load = 1'b1; // R07
                        st_d = ST_DECIDE;
                        cnt_d = step_len - CNT_ONE; // R17
                    end
                    else
                    begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
                ST_DECIDE:
                begin
                    if (cnt_q == CNT_ZERO)
                    begin
                        sar_decide = 1'b1; // R16
                        cnt_d = step_len - CNT_ONE;
                        if (sar_last)
                        begin
                            irq_d = 1'b1; // R04 R05
                            if (src_hw_q)
                            begin
                                st_d = ST_IDLE; // R04
                            end
                            else
                            begin
                                st_d = ST_SAMPLE; // R05
                                cnt_d = sample_len - CNT_ONE;
                            end
                        end
                    end
                    else
                    begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                end
            endcase
        end
        // route only the selected channel while converting, hold while deciding
        sel_d = (st_d == ST_IDLE) ? '0 : (CH_N'(1) << mode_d.chan); // R06 R15
        hold_d = (st_d == ST_DECIDE); // R10
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            src_hw_q <= 1'b0;
            irq_q <= 1'b0;
            sel_q <= '0;
            hold_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            src_hw_q <= src_hw_d;
            irq_q <= irq_d;
            sel_q <= sel_d;
            hold_q <= hold_d;
        end
    end

    // approximation register stepping
    sas_sar_core #(.W(DATA_W)) u_sar (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load(sar_load),
        .decide(sar_decide),
        .comp_ge(cmp_s2_q),
        .approx(sar_approx),
        .decided(sar_decided),
        .last(sar_last)
    );

    assign conversion_done_irq = irq_q;
    assign analog_sel = sel_q;
    assign sample_hold = hold_q;
    assign ladder_tap = sar_approx; // R16

    // ****************************************
    // assertions
    // ****************************************
    a_done_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
        conversion_done_irq |-> result_q == $past(sar_decided))
        else $error("result not loaded at end of conversion");

    a_hold_decide: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
        st_q == ST_DECIDE |-> sample_hold && $onehot(analog_sel))
        else $error("not holding during bit decisions");

    a_sample_open: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
        st_q == ST_SAMPLE |-> !sample_hold)
        else $error("hold during sampling interval");

    a_chan_route: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
        st_q != ST_IDLE |-> analog_sel == (CH_N'(1) << mode_q.chan))
        else $error("wrong channel routed");

    a_hw_single: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
        conversion_done_irq && src_hw_q && !$past(reg_wr) |-> st_q == ST_IDLE ##1 !conversion_done_irq)
        else $error("hardware conversion did not stop");

    a_sw_repeat: assert property (@(posedge sys_clk) disable iff (!rst_b) // R05
        conversion_done_irq && !src_hw_q && mode_q.run |-> st_q == ST_SAMPLE)
        else $error("software conversion did not repeat");

    a_stop_run: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
        !mode_q.run && !sw_start |=> st_q == ST_IDLE && !sample_hold)
        else $error("converter runs with run bit clear");

    a_sw_start: assert property (@(posedge sys_clk) disable iff (!rst_b) // R03
        sw_start |=> st_q == ST_SAMPLE && !src_hw_q)
        else $error("software write did not start conversion");

    a_hw_start: assert property (@(posedge sys_clk) disable iff (!rst_b) // R02
        hw_start && !wr_mode |=> st_q == ST_SAMPLE && src_hw_q)
        else $error("trigger did not start conversion");

    a_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
        st_q == ST_DECIDE && $past(st_q) == ST_SAMPLE |-> ladder_tap == SAR_MSB)
        else $error("first trial is not the msb");

endmodule

// [sas_analog_src.sv]
// sas_analog_src: behavioural analog sources and comparator facing the sequencer
`timescale 1ns/100ps
module sas_analog_src
    import sas_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // channel levels chosen by the bench
    input wire logic [CH_N*DATA_W-1:0] levels,
    // front end driven by the sequencer
    input wire logic [CH_N-1:0] analog_sel,
    input wire logic sample_hold,
    input wire logic [DATA_W-1:0] ladder_tap,
    // comparator decision
    output logic comp_ge
);
    logic [DATA_W-1:0] held_q = 8'h00;
    logic [DATA_W-1:0] held_d;

    // ****************************************
    // sample and hold
    // ****************************************
    // track the one switched-in channel; none or several garble the node
    always_comb
    begin
        held_d = ~held_q;
        for (int i = 0; i < CH_N; i++)
        begin
            if (analog_sel == (CH_N'(1) << i))
            begin
                held_d = levels[i*DATA_W +: DATA_W];
            end
        end
        if (sample_hold)
        begin
            held_d = held_q;
        end
    end

    // capacitor voltage, updated each clock
    always @(posedge sys_clk)
    begin
        held_q <= held_d;
    end

    // comparator: high when the held input is at least the tap
    assign comp_ge = (held_q >= ladder_tap);
endmodule

// [test_sar_adc_sequencer.sv]
// test_sar_adc_sequencer: self-checking bench for the converter sequencer
`timescale 1ns/100ps
module test_sar_adc_sequencer
    import sas_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic external_trigger_input = 1'b0;
    logic conversion_done_irq;
    logic [CH_N-1:0] analog_sel;
    logic sample_hold;
    logic [DATA_W-1:0] ladder_tap;
    logic comp_ge;
    logic [CH_N-1:0] port_analog_mask;
    logic [63:0] levels = 64'hC301AA557F80FF00;
    logic [2:0] rcode [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h0};
    int step [5] = '{16, 8, 10, 20, 20};
    int err_count = 0;
    int checks = 0;

    // ****************************************
    // clock, design and partner
    // ****************************************
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    sas_sequencer DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_trigger_input(external_trigger_input), .conversion_done_irq(conversion_done_irq),
        .analog_sel(analog_sel), .sample_hold(sample_hold), .ladder_tap(ladder_tap), .comp_ge(comp_ge),
        .port_analog_mask(port_analog_mask));

    sas_analog_src src (.sys_clk(sys_clk), .levels(levels), .analog_sel(analog_sel),
        .sample_hold(sample_hold), .ladder_tap(ladder_tap), .comp_ge(comp_ge));

    // ****************************************
    // tasks
    // ****************************************
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one register write, taken at the next edge
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_wr = 1'b0;
    endtask

    // one register read; the software test reads the result here while conversions repeat
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_rd = 1'b0;
        @(posedge sys_clk);
        #2;
        d = reg_rdata;
    endtask

    // count cycles to the done pulse, noting hold onset and channel switch
    task automatic wait_conv(output int n, output int hold_n, output logic [7:0] sel);
        n = 0;
        hold_n = 0;
        sel = 8'h00;
        do
        begin
            @(posedge sys_clk);
            #2;
            n++;
            if (n == 5)
                sel = analog_sel;
            if (hold_n == 0 && sample_hold === 1'b1)
                hold_n = n;
        end
        while (conversion_done_irq !== 1'b1 && n < 400);
    endtask

    // count done pulses over a span
    task automatic quiet(input int cycles, output int hits);
        hits = 0;
        repeat (cycles)
        begin
            @(posedge sys_clk);
            #2;
            if (conversion_done_irq !== 1'b0)
                hits++;
        end
    endtask

    // rising edge on the trigger pin, held four cycles
    task automatic trig_pulse();
        @(posedge sys_clk);
        #2;
        external_trigger_input = 1'b1;
        repeat (4) @(posedge sys_clk);
        #2;
        external_trigger_input = 1'b0;
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        int n;
        int hn;
        int hits;
        int s;
        logic [7:0] sel;
        logic [7:0] d;
        repeat (3) @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        chk({reg_rdata, analog_sel}, 16'h0000);
        chk({conversion_done_irq, sample_hold, port_analog_mask}, 16'h0000);
        reg_read(ADDR_MODE, d);
        chk(d, MODE_RESET);
        reg_read(ADDR_INSEL, d);
        chk(d, INSEL_RESET);
        reg_read(16'hFF82, d);
        chk(d, READ_ZERO);
        // input count 0..8 gives that many low pins as analog
        for (int k = 0; k <= 8; k++)
        begin
            reg_write(ADDR_INSEL, 8'(k));
            reg_read(ADDR_INSEL, d);
            chk(d, 16'(k));
            chk(port_analog_mask, 16'((9'h001 << k) - 9'h001));
        end
        // software start on every channel and rate, two back-to-back conversions each
        for (int ch = 0; ch < 8; ch++)
        begin
            s = step[ch % 5];
            reg_write(ADDR_MODE, {1'b1, 1'b0, rcode[ch % 5][2:1], 3'(ch), rcode[ch % 5][0]});
            wait_conv(n, hn, sel);
            chk(16'(n), 16'(10 * s));
            chk(16'(hn), 16'(2 * s));
            chk(sel, 16'(8'h01 << ch));
            wait_conv(n, hn, sel);
            chk(16'(n), 16'(10 * s));
            chk(16'(hn), 16'(2 * s));
            chk(sel, 16'(8'h01 << ch));
            reg_read(ADDR_RESULT, d);
            chk(d, levels[ch*8 +: 8]);
        end
        // clearing run mid-conversion stops it with no done pulse
        reg_write(ADDR_MODE, 8'h81);
        repeat (50) @(posedge sys_clk);
        reg_write(ADDR_MODE, 8'h01);
        @(posedge sys_clk);
        #2;
        chk(analog_sel, 16'h0000);
        quiet(300, hits);
        chk(16'(hits), 16'h0000);
        // hardware start: idle until a trigger edge, one conversion per edge taken in idle; an edge mid-conversion is ignored
        reg_write(ADDR_MODE, 8'hC7);
        quiet(300, hits);
        chk(16'(hits), 16'h0000);
        trig_pulse();
        repeat (40) @(posedge sys_clk);
        trig_pulse();
        wait_conv(n, hn, sel);
        chk(conversion_done_irq, 1'b1);
        chk(sel, 16'h0008);
        quiet(400, hits);
        chk(16'(hits), 16'h0000);
        chk(analog_sel, 16'h0000);
        reg_read(ADDR_RESULT, d);
        chk(d, 16'h007F);
        trig_pulse();
        wait_conv(n, hn, sel);
        chk(conversion_done_irq, 1'b1);
        conclude();
    end

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        conclude();
    end
endmodule
